// ===== src/vsc_pkg.sv
// shared constants and types of the output voltage setpoint control
package vsc_pkg;
	// ----------------------------------------
	// bus and data widths
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CODE_W = 5;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_OPERATION = 8'h01;
	localparam logic [7:0] ADDR_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_VOUT_COMMAND = 8'h21;
	localparam logic [7:0] ADDR_VOUT_TRIM = 8'h22;
	localparam logic [7:0] ADDR_VOUT_MAX = 8'h24;
	localparam logic [7:0] ADDR_MARGIN_HIGH = 8'h25;
	localparam logic [7:0] ADDR_MARGIN_LOW = 8'h26;
	localparam logic [7:0] ADDR_STATUS = 8'h78;
	localparam logic [7:0] ADDR_TARGET = 8'h8b;
	localparam logic [7:0] ADDR_STRAP_NOMINAL = 8'hd0;
	// ----------------------------------------
	// field positions and encodings
	// ----------------------------------------
	localparam int OP_ON_BIT = 7;
	localparam int OP_MARGIN_LSB = 4;
	localparam logic [1:0] MARGIN_NONE = 2'h0;
	localparam logic [1:0] MARGIN_LOW = 2'h1;
	localparam logic [1:0] MARGIN_HIGH = 2'h2;
	localparam int ONOFF_SRC_LSB = 0;
	localparam int ONOFF_POL_BIT = 2;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_OPERATION = 2'h1;
	localparam logic [1:0] SRC_BOTH = 2'h2;
	localparam logic [1:0] SRC_ALWAYS = 2'h3;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] OPERATION_RST = 8'h00;
	localparam logic [2:0] ON_OFF_CONFIG_RST = 3'h4;
	localparam logic [15:0] VOUT_MAX_RST = 16'hffff;
	localparam logic [15:0] VOUT_ZERO = 16'h0000;
	// ----------------------------------------
	// percentages of nominal or target, percent units
	// ----------------------------------------
	localparam logic [7:0] MARGIN_UP_PCT = 8'h69;
	localparam logic [7:0] MARGIN_DN_PCT = 8'h5f;
	localparam logic [7:0] CEILING_PCT = 8'h6e;
	localparam logic [7:0] PG_ON_PCT = 8'h5a;
	localparam logic [7:0] PG_OFF_PCT = 8'h55;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int STRAP_SETTLE_NS = 1000;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// control states, gray along the path
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h3
	} vsc_state_type;
endpackage

// ===== src/vsc_strap_decode.sv
// strap code to nominal millivolt lookup with registered result
`timescale 1ns/1ps
`default_nettype none
module vsc_strap_decode (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic take_in,
	input wire logic [vsc_pkg::CODE_W-1:0] code_in,
	output logic [vsc_pkg::DATA_W-1:0] nominal_out,
	output logic valid_out
);
	import vsc_pkg::*;

	typedef struct packed {
		logic [15:0] nominal;
		logic valid;
	} vsc_dec_reg_type;

	vsc_dec_reg_type r;
	vsc_dec_reg_type n;

	// ----------------------------------------
	// lookup, codes past the table read as open
	// ----------------------------------------
	function automatic logic [15:0] strap_mv(input logic [4:0] c);
		case (c)
			5'h00, 5'h01: strap_mv = 16'h0258;
			5'h02: strap_mv = 16'h028a;
			5'h03: strap_mv = 16'h02bc;
			5'h04: strap_mv = 16'h02ee;
			5'h05: strap_mv = 16'h0320;
			5'h06: strap_mv = 16'h0352;
			5'h07: strap_mv = 16'h0384;
			5'h08: strap_mv = 16'h03b6;
			5'h09: strap_mv = 16'h03e8;
			5'h0a: strap_mv = 16'h041a;
			5'h0b: strap_mv = 16'h044c;
			5'h0c: strap_mv = 16'h047e;
			5'h0d: strap_mv = 16'h04b0;
			5'h0e: strap_mv = 16'h04e2;
			5'h0f: strap_mv = 16'h0514;
			5'h10: strap_mv = 16'h0578;
			5'h11: strap_mv = 16'h05dc;
			5'h12: strap_mv = 16'h0640;
			5'h13: strap_mv = 16'h06a4;
			5'h14: strap_mv = 16'h0708;
			default: strap_mv = 16'h04b0;
		endcase
	endfunction

	// ----------------------------------------
	// latch once; later takes are ignored
	// ----------------------------------------
	always_comb begin
		n = r;
		if (take_in && !r.valid) begin
			n.nominal = strap_mv(code_in);
			n.valid = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign nominal_out = r.nominal;
	assign valid_out = r.valid;
endmodule
`default_nettype wire

// ===== src/vsc_setpoint_ctrl.sv
// output on/off source and voltage setpoint control, top level
// Behaviour
// - on/off source is pin, operation, pin and operation, or always on
// - enable pin polarity selectable, active high or active low
// - after reset source is pin alone, active high
// - strap sampled once after power-up; later strap changes ignored
// - strap decodes to 0.60 to 1.80 V; open strap gives 1.20 V
// - a vout command write replaces the strap nominal, still ceiling-limited
// - with loop compensation, no broadcast margining in pin-only mode
// - margin levels default to plus and minus 5 percent, reprogrammable
// - operation selects nominal, margin high or margin low, any source
// - signed trim is added to the selected level: nominal, margin high or margin low
// - target clamped to 110 percent of strap nominal
// - clamp acts on target only; vout command reads back as written
// - vout max may lower the ceiling, never raise it
// - while enabled, raise limited by band of the setpoint at enable
// - power good low in ramp and fault; on above 90, off below 85
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vsc_setpoint_ctrl #(
	parameter bit HAS_DLC = 1'b1
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic ENABLE_PIN_IN,
	input wire logic [vsc_pkg::CODE_W-1:0] SETPOINT_STRAP_PIN_IN,
	input wire logic [vsc_pkg::DATA_W-1:0] VOUT_SENSE_IN,
	input wire logic FAULT_IN,
	input wire logic BCAST_IN,
	input wire logic [vsc_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [vsc_pkg::DATA_W-1:0] WR_DATA_IN,
	input wire logic WR_STROBE_IN,
	input wire logic RD_STROBE_IN,
	output logic [vsc_pkg::DATA_W-1:0] RD_DATA_OUT,
	output logic OUTPUT_ENABLE_OUT,
	output logic [vsc_pkg::DATA_W-1:0] VOUT_TARGET_OUT,
	output logic POWER_GOOD_PIN_OUT,
	output logic POWER_GOOD_PIN_OE_OUT,
	output logic STRAP_VALID_OUT
);
	import vsc_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (DATA_W != 16) begin : g_bad_width
		$error("setpoint control needs 16-bit data");
	end
	if (STRAP_SETTLE_CYC < 1 || STRAP_SETTLE_CYC > 63) begin : g_bad_settle
		$error("strap settle count out of range");
	end
	if (CODE_W != 5) begin : g_bad_code
		$error("strap decoder table expects a 5-bit code");
	end
	if (PG_OFF_PCT >= PG_ON_PCT) begin : g_bad_pg_band
		$error("power good needs hysteresis, off level below on level");
	end
	if (CEILING_PCT < 8'h64) begin : g_bad_ceiling
		$error("ceiling below nominal would block the strap value");
	end
	if (MARGIN_UP_PCT <= 8'h64) begin : g_bad_margin_up
		$error("high margin default must sit above nominal");
	end
	if (MARGIN_DN_PCT >= 8'h64) begin : g_bad_margin_dn
		$error("low margin default must sit below nominal");
	end
	if (VOUT_MAX_RST != 16'hffff) begin : g_bad_max_rst
		$error("vout max must reset open so only the strap ceiling acts");
	end
	if (ON_OFF_CONFIG_RST[ONOFF_SRC_LSB +: 2] != SRC_PIN
		|| !ON_OFF_CONFIG_RST[ONOFF_POL_BIT]) begin : g_bad_onoff_rst
		$error("reset on/off source must be the pin, active high");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		vsc_state_type st;
		logic [5:0] cnt;
		logic [2:0] en_sync;
		logic en_level;
		logic [14:0] strap_sync;
		logic strap_take;
		logic [7:0] operation;
		logic [2:0] onoff;
		logic [15:0] vout_command;
		logic cmd_set;
		logic [15:0] vout_trim;
		logic [15:0] vout_max;
		logic [15:0] margin_high;
		logic [15:0] margin_low;
		logic mh_set;
		logic ml_set;
		logic out_en;
		logic [15:0] enable_cap;
		logic [15:0] target;
		logic pg;
		logic pg_oe;
		logic [15:0] rd_data;
	} vsc_ctrl_reg_type;

	vsc_ctrl_reg_type r;
	vsc_ctrl_reg_type n;

	logic [15:0] strap_nominal;
	logic strap_valid;

	// ----------------------------------------
	// arithmetic helpers
	// ----------------------------------------
	function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
		logic [23:0] prod;
		prod = {8'h00, v} * {16'h0000, p};
		// truncates, so thresholds land up to one millivolt low
		pct = 16'(prod / 24'h000064);
	endfunction

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	// raise ceiling while enabled, chosen by the setpoint at enable time
	function automatic logic [15:0] raise_limit(input logic [15:0] v);
		if (v < 16'h03dc) begin
			raise_limit = 16'h04b0;
		end else if (v < 16'h0567) begin
			raise_limit = 16'h06a4;
		end else if (v < 16'h07b7) begin
			raise_limit = 16'h09c4;
		end else if (v < 16'h095e) begin
			raise_limit = 16'h0b9a;
		end else if (v < 16'h0b93) begin
			raise_limit = 16'h0e60;
		end else begin
			raise_limit = 16'h122a;
		end
	endfunction

	// ----------------------------------------
	// field decode, shared by write and target paths
	// ----------------------------------------
	function automatic logic [1:0] src_of(input logic [2:0] cfg);
		src_of = cfg[ONOFF_SRC_LSB +: 2];
	endfunction

	function automatic logic [1:0] margin_of(input logic [7:0] op);
		margin_of = op[OP_MARGIN_LSB +: 2];
	endfunction

	function automatic logic op_on(input logic [7:0] op);
		op_on = op[OP_ON_BIT];
	endfunction

	// ----------------------------------------
	// strap decoder, sampled once
	// ----------------------------------------
	vsc_strap_decode u_strap (
		.CLOCK_IN(CLOCK_IN),
		.RST_IN(RST_IN),
		.take_in(r.strap_take),
		.code_in(r.strap_sync[14:10]),
		.nominal_out(strap_nominal),
		.valid_out(strap_valid)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic pin_active;
	logic src_on;
	logic [1:0] margin_sel;
	logic [15:0] nominal;
	logic [15:0] mh_level;
	logic [15:0] ml_level;
	logic [15:0] base;
	logic signed [17:0] sum;
	logic [15:0] trimmed;
	logic [15:0] ceiling;
	logic [15:0] eff;
	logic bcast_block;

	always_comb begin
		n = r;
		n.strap_take = 1'b0;
		n.rd_data = VOUT_ZERO;
		n.en_sync = {r.en_sync[1:0], ENABLE_PIN_IN};
		if (r.en_sync[1] == r.en_sync[2]) begin
			n.en_level = r.en_sync[2];
		end
		n.strap_sync = {r.strap_sync[9:0], SETPOINT_STRAP_PIN_IN};

		// power-up sequence; the strap is only looked at here
		// two agreeing sync stages keep a still-settling strap from latching
		case (r.st)
			ST_INIT: begin
				if (r.cnt < 6'(STRAP_SETTLE_CYC)) begin
					n.cnt = r.cnt + 6'h01;
				end else if (r.strap_sync[9:5] == r.strap_sync[14:10]) begin
					n.strap_take = 1'b1;
					n.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (strap_valid) begin
					if (!r.cmd_set) begin
						n.vout_command = strap_nominal;
					end
					n.st = ST_RUN;
				end
			end
			ST_RUN: begin
				n.st = ST_RUN;
			end
			default: begin
				n.st = ST_INIT;
			end
		endcase

		// on/off source
		pin_active = r.onoff[ONOFF_POL_BIT] ? r.en_level : ~r.en_level;
		case (src_of(r.onoff))
			SRC_PIN: src_on = pin_active;
			SRC_OPERATION: src_on = op_on(r.operation);
			SRC_BOTH: src_on = pin_active & op_on(r.operation);
			default: src_on = 1'b1;
		endcase

		// register writes
		bcast_block = HAS_DLC && BCAST_IN
			&& (src_of(r.onoff) == SRC_PIN);
		if (WR_STROBE_IN) begin
			case (ADDR_IN)
				ADDR_OPERATION: begin
					n.operation = WR_DATA_IN[7:0];
					if (bcast_block) begin
						n.operation[OP_MARGIN_LSB +: 2] = margin_of(r.operation);
					end
				end
				ADDR_ON_OFF_CONFIG: n.onoff = WR_DATA_IN[2:0];
				ADDR_VOUT_COMMAND: begin
					n.vout_command = WR_DATA_IN;
					n.cmd_set = 1'b1;
				end
				ADDR_VOUT_TRIM: n.vout_trim = WR_DATA_IN;
				ADDR_VOUT_MAX: n.vout_max = WR_DATA_IN;
				ADDR_MARGIN_HIGH: begin
					n.margin_high = WR_DATA_IN;
					n.mh_set = 1'b1;
				end
				ADDR_MARGIN_LOW: begin
					n.margin_low = WR_DATA_IN;
					n.ml_set = 1'b1;
				end
				default: n.st = n.st;
			endcase
		end

		// target path
		nominal = r.vout_command;
		mh_level = r.mh_set ? r.margin_high : pct(nominal, MARGIN_UP_PCT);
		ml_level = r.ml_set ? r.margin_low : pct(nominal, MARGIN_DN_PCT);
		margin_sel = margin_of(r.operation);
		case (margin_sel)
			MARGIN_HIGH: base = mh_level;
			MARGIN_LOW: base = ml_level;
			default: base = nominal;
		endcase
		sum = $signed({2'b00, base}) + $signed({{2{r.vout_trim[15]}}, r.vout_trim});
		if (sum < 18'sh00000) begin
			trimmed = VOUT_ZERO;
		end else if (sum > 18'sh0ffff) begin
			trimmed = 16'hffff;
		end else begin
			trimmed = sum[15:0];
		end
		// vout max only ever narrows the strap ceiling
		ceiling = min16(pct(strap_nominal, CEILING_PCT), r.vout_max);
		eff = min16(trimmed, ceiling);
		if (r.out_en) begin
			eff = min16(eff, raise_limit(r.enable_cap));
		end

		// enable, only after the strap is known
		// band is frozen at the enable edge; a disable frees the raise again
		n.out_en = src_on && (r.st == ST_RUN);
		if (n.out_en && !r.out_en) begin
			n.enable_cap = min16(trimmed, ceiling);
		end
		n.target = (r.st == ST_RUN) ? eff : VOUT_ZERO;

		// power good with hysteresis; held low while ramping or faulted
		if (!r.out_en || FAULT_IN) begin
			n.pg = 1'b0;
		end else if (!r.pg && VOUT_SENSE_IN >= pct(r.target, PG_ON_PCT)) begin
			n.pg = 1'b1;
		end else if (r.pg && VOUT_SENSE_IN < pct(r.target, PG_OFF_PCT)) begin
			n.pg = 1'b0;
		end
		n.pg_oe = ~n.pg;

		// read data, valid only in the cycle after the strobe
		if (RD_STROBE_IN) begin
			case (ADDR_IN)
				ADDR_OPERATION: n.rd_data = {8'h00, r.operation};
				ADDR_ON_OFF_CONFIG: n.rd_data = {13'h0000, r.onoff};
				ADDR_VOUT_COMMAND: n.rd_data = r.vout_command;
				ADDR_VOUT_TRIM: n.rd_data = r.vout_trim;
				ADDR_VOUT_MAX: n.rd_data = r.vout_max;
				ADDR_MARGIN_HIGH: n.rd_data = mh_level;
				ADDR_MARGIN_LOW: n.rd_data = ml_level;
				ADDR_STATUS: n.rd_data = {10'h000, r.st, pin_active,
					strap_valid, r.pg, r.out_en};
				ADDR_TARGET: n.rd_data = r.target;
				ADDR_STRAP_NOMINAL: n.rd_data = strap_nominal;
				default: n.rd_data = VOUT_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			r <= '0;
			r.st <= ST_INIT;
			r.operation <= OPERATION_RST;
			r.onoff <= ON_OFF_CONFIG_RST;
			r.vout_max <= VOUT_MAX_RST;
			r.pg_oe <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign RD_DATA_OUT = r.rd_data;
	assign OUTPUT_ENABLE_OUT = r.out_en;
	assign VOUT_TARGET_OUT = r.target;
	// open drain: level reads low whenever the pin is pulled
	assign POWER_GOOD_PIN_OUT = r.pg;
	assign POWER_GOOD_PIN_OE_OUT = r.pg_oe;
	assign STRAP_VALID_OUT = strap_valid;
endmodule
`default_nettype wire

// ===== verif/vsc_checker.sv
// port assertions of the setpoint control
`timescale 1ns/1ps
`default_nettype none
module vsc_checker (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic FAULT_IN,
	input wire logic [vsc_pkg::DATA_W-1:0] VOUT_SENSE_IN,
	input wire logic [vsc_pkg::DATA_W-1:0] VOUT_TARGET_OUT,
	input wire logic OUTPUT_ENABLE_OUT,
	input wire logic POWER_GOOD_PIN_OUT,
	input wire logic POWER_GOOD_PIN_OE_OUT,
	input wire logic STRAP_VALID_OUT
);
	import vsc_pkg::*;
	logic [31:0] on_lim;
	logic [31:0] off_lim;
	logic [5:0] age;
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (RST_IN);
	// thresholds truncate, like the percent math of the block
	always_comb begin
		on_lim = 32'(VOUT_TARGET_OUT) * 32'(PG_ON_PCT) / 32'h64;
		off_lim = 32'(VOUT_TARGET_OUT) * 32'(PG_OFF_PCT) / 32'h64;
	end
	// cycles since reset, saturating so it never wraps
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			age <= 6'h0;
		end else if (age != 6'h3f) begin
			age <= age + 6'h1;
		end
	end
	a_pg_oe_inverse: assert property (POWER_GOOD_PIN_OE_OUT == !POWER_GOOD_PIN_OUT)
		else $error("power good drive not inverse of level");
	a_pg_after_off: assert property (!OUTPUT_ENABLE_OUT [*2] |-> !POWER_GOOD_PIN_OUT)
		else $error("power good high with output off");
	a_pg_fault_drop: assert property (FAULT_IN |=> !POWER_GOOD_PIN_OUT)
		else $error("power good kept through fault");
	a_pg_low_drop: assert property (32'(VOUT_SENSE_IN) < off_lim && $stable(VOUT_TARGET_OUT)
		|=> !POWER_GOOD_PIN_OUT)
		else $error("power good kept below low threshold");
	a_pg_rise_cause: assert property ($rose(POWER_GOOD_PIN_OUT) |->
		!$past(FAULT_IN) && 32'($past(VOUT_SENSE_IN)) >= $past(on_lim))
		else $error("power good rose without cause");
	a_strap_held: assert property ($past(STRAP_VALID_OUT) |-> STRAP_VALID_OUT)
		else $error("strap latch dropped");
	a_strap_early: assert property (age < 6'h28 |-> !STRAP_VALID_OUT)
		else $error("strap taken before settling");
	a_strap_late: assert property (age == 6'h3f |-> STRAP_VALID_OUT)
		else $error("strap never taken");
	a_off_until_strap: assert property (!STRAP_VALID_OUT |-> !OUTPUT_ENABLE_OUT)
		else $error("output on before strap known");
	a_tgt_wait_strap: assert property (!STRAP_VALID_OUT |-> VOUT_TARGET_OUT == '0)
		else $error("target set before strap known");
	c_pg_up: cover property ($rose(POWER_GOOD_PIN_OUT));
	c_en_up: cover property ($rose(OUTPUT_ENABLE_OUT));
	c_fault: cover property (FAULT_IN && POWER_GOOD_PIN_OUT);
endmodule
bind vsc_setpoint_ctrl vsc_checker chk_u (
	.CLOCK_IN(CLOCK_IN),
	.RST_IN(RST_IN),
	.FAULT_IN(FAULT_IN),
	.VOUT_SENSE_IN(VOUT_SENSE_IN),
	.VOUT_TARGET_OUT(VOUT_TARGET_OUT),
	.OUTPUT_ENABLE_OUT(OUTPUT_ENABLE_OUT),
	.POWER_GOOD_PIN_OUT(POWER_GOOD_PIN_OUT),
	.POWER_GOOD_PIN_OE_OUT(POWER_GOOD_PIN_OE_OUT),
	.STRAP_VALID_OUT(STRAP_VALID_OUT)
);
`default_nettype wire

// ===== verif/vsc_load_model.sv
// board model: enable driver and output rail seen by the sense input
`timescale 1ns/1ps
`default_nettype none
module vsc_load_model (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic pin_req_in,
	input wire logic sag_in,
	input wire logic out_en_in,
	input wire logic [15:0] target_in,
	output logic pin_out,
	output logic [15:0] sense_out
);
	logic [15:0] goal;
	initial pin_out = 1'h0;
	// no sync clock on this board, so the pin only moves from steady state
	always @(pin_req_in) pin_out <= #7 pin_req_in;
	// a sag pulls the rail to three quarters, below the drop threshold
	always_comb goal = !out_en_in ? 16'h0 : sag_in ? target_in - (target_in >> 2) : target_in;
	// slow ramp so power good must wait for the rail
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sense_out <= 16'h0;
		end else if (sense_out + 16'h40 < goal) begin
			sense_out <= sense_out + 16'h40;
		end else begin
			sense_out <= goal;
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench of the setpoint control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vsc_pkg::*;
	logic clk, rst, pin_req, sag, fault, bcast, ws, rs, en_pin, oe, pg, pg_oe, sv, rd_seen, x;
	logic [4:0] strap;
	logic [7:0] addr;
	logic [15:0] wd, rdd, tgt, sense;
	logic [31:0] q[$];
	logic [31:0] rnd, e;
	int n_errors, total_checks;
	// write then expected target: {address, data, target}
	logic [39:0] steps [16] = '{
		{ADDR_VOUT_COMMAND, 16'h07d0, 16'h04ba},
		{ADDR_VOUT_COMMAND, 16'h03e8, 16'h03e8},
		{ADDR_VOUT_TRIM, 16'hffce, 16'h03b6},
		{ADDR_VOUT_TRIM, 16'h012c, 16'h04ba},
		{ADDR_VOUT_TRIM, 16'h0000, 16'h03e8},
		{ADDR_OPERATION, 16'h0020, 16'h041a},
		{ADDR_OPERATION, 16'h0010, 16'h03b6},
		{ADDR_MARGIN_HIGH, 16'h044c, 16'h03b6},
		{ADDR_OPERATION, 16'h0020, 16'h044c},
		{ADDR_MARGIN_HIGH, 16'h05dc, 16'h04ba},
		{ADDR_OPERATION, 16'h0000, 16'h03e8},
		{ADDR_VOUT_MAX, 16'h03d4, 16'h03d4},
		{ADDR_VOUT_TRIM, 16'h0064, 16'h03d4},
		{ADDR_VOUT_MAX, 16'h07d0, 16'h044c},
		{ADDR_VOUT_MAX, 16'hffff, 16'h044c},
		{ADDR_VOUT_TRIM, 16'h0000, 16'h03e8}
	};
	vsc_setpoint_ctrl dut_u (.CLOCK_IN(clk), .RST_IN(rst), .ENABLE_PIN_IN(en_pin),
		.SETPOINT_STRAP_PIN_IN(strap), .VOUT_SENSE_IN(sense), .FAULT_IN(fault),
		.BCAST_IN(bcast), .ADDR_IN(addr), .WR_DATA_IN(wd), .WR_STROBE_IN(ws),
		.RD_STROBE_IN(rs), .RD_DATA_OUT(rdd), .OUTPUT_ENABLE_OUT(oe),
		.VOUT_TARGET_OUT(tgt), .POWER_GOOD_PIN_OUT(pg), .POWER_GOOD_PIN_OE_OUT(pg_oe),
		.STRAP_VALID_OUT(sv));
	vsc_load_model load_u (.clock_in(clk), .rst_in(rst), .pin_req_in(pin_req), .sag_in(sag),
		.out_en_in(oe), .target_in(tgt), .pin_out(en_pin), .sense_out(sense));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] strap_mv(input logic [4:0] c);
		if (c > 5'h14) return 16'h04b0;
		if (c > 5'h0f) return 16'h0578 + 16'h0064 * (c - 5'h10);
		return (c == 5'h0) ? 16'h0258 : 16'h0226 + 16'h0032 * c;
	endfunction
	// one gap cycle per transfer keeps strobes single-driven per step
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic b);
		@(posedge clk);
		addr <= a;
		wd <= d;
		bcast <= b;
		ws <= w;
		rs <= !w;
		@(posedge clk);
		ws <= 1'h0;
		rs <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
		q.push_back({m, v});
		bus(1'h0, a, 16'h0, 1'h0);
	endtask
	task automatic boot(input logic [4:0] c);
		// let a pending read answer be compared before reset clears it
		@(posedge clk);
		rst <= 1'h1;
		strap <= c;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 200 && sv !== 1'h1; i++) @(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) rd_seen <= rs && !rst;
	always @(negedge clk) begin
		if (rd_seen) begin
			e = q.pop_front();
			total_checks++;
			if ((rdd & e[31:16]) !== e[15:0]) begin
				n_errors++;
				$display("BAD %0t read %h want %h", $time, rdd, e[15:0]);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end
	initial begin
		rst = 1'h1;
		{ws, rs, bcast, pin_req, sag, fault} = 6'h0;
		addr = 8'h0;
		wd = 16'h0;
		strap = 5'h0;
		rnd = 32'h7c6d;
		for (int c = 0; c < 23; c++) begin
			boot(5'(c));
			rd(ADDR_STRAP_NOMINAL, 16'hffff, strap_mv(5'(c)));
		end
		strap <= 5'h03;
		repeat (60) @(posedge clk);
		rd(ADDR_STRAP_NOMINAL, 16'hffff, 16'h04b0);
		rd(ADDR_TARGET, 16'hffff, 16'h04b0);
		boot(5'h0b);
		rd(ADDR_OPERATION, 16'hffff, {8'h0, OPERATION_RST});
		rd(ADDR_ON_OFF_CONFIG, 16'hffff, {13'h0, 1'h1, SRC_PIN});
		rd(ADDR_VOUT_MAX, 16'hffff, 16'hffff);
		rd(8'h55, 16'hffff, 16'h0000);
		rd(ADDR_VOUT_COMMAND, 16'hffff, 16'h044c);
		rd(ADDR_MARGIN_LOW, 16'hffff, 16'h0415);
		repeat (4) begin
			rnd = lfsr(rnd);
			bus(1'h1, ADDR_VOUT_COMMAND, rnd[15:0], 1'h0);
			rd(ADDR_VOUT_COMMAND, 16'hffff, rnd[15:0]);
			rd(ADDR_TARGET, 16'hffff, (rnd[15:0] < 16'h04ba) ? rnd[15:0] : 16'h04ba);
		end
		for (int i = 0; i < 16; i++) begin
			bus(1'h1, steps[i][39:32], steps[i][31:16], 1'h0);
			rd(ADDR_TARGET, 16'hffff, steps[i][15:0]);
		end
		bus(1'h1, ADDR_OPERATION, 16'h0020, 1'h1);
		rd(ADDR_OPERATION, 16'h0030, 16'h0000);
		bus(1'h1, ADDR_ON_OFF_CONFIG, 16'h0005, 1'h0);
		bus(1'h1, ADDR_OPERATION, 16'h0020, 1'h1);
		rd(ADDR_OPERATION, 16'h0030, 16'h0020);
		// no command writes from here on while the output may turn on
		for (int k = 0; k < 32; k++) begin
			bus(1'h1, ADDR_ON_OFF_CONFIG, {13'h0, k[2], k[1:0]}, 1'h0);
			bus(1'h1, ADDR_OPERATION, {8'h0, k[4], 7'h0}, 1'h0);
			pin_req <= k[3];
			repeat (10) @(posedge clk);
			x = k[1] ? (k[0] | ((k[3] == k[2]) & k[4])) : (k[0] ? k[4] : (k[3] == k[2]));
			rd(ADDR_STATUS, 16'h0001, {15'h0, x});
		end
		repeat (60) @(posedge clk);
		rd(ADDR_STATUS, 16'h0002, 16'h0002);
		fault <= 1'h1;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS, 16'h0002, 16'h0000);
		fault <= 1'h0;
		repeat (60) @(posedge clk);
		rd(ADDR_STATUS, 16'h0002, 16'h0002);
		sag <= 1'h1;
		repeat (10) @(posedge clk);
		rd(ADDR_STATUS, 16'h0002, 16'h0000);
		sag <= 1'h0;
		repeat (3) @(posedge clk);
		// low setpoint at enable through trim, then raise while on and after off
		pin_req <= 1'h0;
		boot(5'h14);
		bus(1'h1, ADDR_VOUT_TRIM, 16'hfc7c, 1'h0);
		bus(1'h1, ADDR_ON_OFF_CONFIG, 16'h0007, 1'h0);
		repeat (40) @(posedge clk);
		bus(1'h1, ADDR_VOUT_TRIM, 16'h0000, 1'h0);
		rd(ADDR_TARGET, 16'hffff, 16'h04b0);
		bus(1'h1, ADDR_ON_OFF_CONFIG, 16'h0004, 1'h0);
		repeat (4) @(posedge clk);
		rd(ADDR_TARGET, 16'hffff, 16'h0708);
		repeat (3) @(posedge clk);
		results();
	end
endmodule
`default_nettype wire
